/* rtl/sar_conversion_sequencer.sv */
/*
  Conversion sequencer of a 16-bit charge redistribution converter:
  acquisition and conversion switch sequence, binary search, result,
  busy, three throughput modes, power-down, Wishbone register slave.
  Assumes all pins synchronous to clk_i and an analog comparator
  that settles within one clock.
*/

// Operation
// - After acquisition, start converting when start input falls, or is low in low-power mode.
// - Acquire: array common node grounded, all elements on scaler output.
// - Conversion begins: open ground switches, then move array and dummy to reference ground.
// - Trial each of 16 weighted elements, most significant first.
// - After the search, form the output code and drop busy.
// - Result belongs to the sample of the same conversion, no latency.
// - Three modes; fast mode allows up to 570 kSPS.
// - Normal mode runs up to 500 kSPS with no interval limit.
// - Low-power mode saves power between conversions, at most 444 kSPS.
// - Busy rises at conversion start and stays until result latched.
// - Reset high resets logic and aborts any conversion.
// - Low-power mode: start still low at acquisition end converts at once.
// - Power-down: finish current conversion, then block conversions, reduce power.
`timescale 1ns/1ps
module sar_conversion_sequencer
  import sar_seq_pkg::*;
#(
  parameter int unsigned STALE_LIMIT = STALE_CYC
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Converter control pins
  input  wire logic        conversion_start_n_i,
  input  wire logic        power_down_input_i,
  input  wire logic        comparator_i,
  // Switch drives and result
  output logic             busy_o,
  output logic             array_ground_switch_o,
  output logic             dummy_ground_switch_o,
  output logic             inputs_connected_o,
  output logic      [15:0] element_ref_o,
  output logic      [15:0] result_o,
  output logic             result_latch_o,
  output logic             power_save_o,
  output logic             power_reduced_o
);

  typedef enum logic [2:0] {ST_ACQ, ST_OPEN, ST_MOVE, ST_SEARCH, ST_LATCH, ST_PD} state_e;

  state_e      state_q;
  mode_e       mode;
  logic [1:0]  ctrl_q;
  logic [7:0]  acq_min;
  logic [7:0]  per_min;
  logic [7:0]  acq_cnt_q;
  logic        acq_done;
  logic        armed_q;
  logic        trigger;
  logic [15:0] result_q;
  logic        latch_q;
  logic        new_q;
  logic        stale_q;
  logic [15:0] idle_cnt_q;
  logic        wb_req;
  logic        ack_q;
  logic [31:0] dat_q;

  sar_if sar ();

  sar_search u_search (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .bus   (sar.engine)
  );

  assign sar.start = (state_q == ST_MOVE);
  assign sar.comp  = comparator_i;

  // ****************************************
  // Mode select and timing
  // ****************************************
  always_comb begin
    if (ctrl_q[CTRL_FAST_BIT]) begin
      mode = MODE_FAST;
    end else if (ctrl_q[CTRL_LOWP_BIT]) begin
      mode = MODE_LOWP;
    end else begin
      mode = MODE_NORMAL;
    end
  end

  always_comb begin
    unique case (mode)
      MODE_FAST: begin
        acq_min = 8'(FAST_ACQ_CYC);
        per_min = 8'(FAST_PERIOD_CYC);
      end
      MODE_LOWP: begin
        acq_min = 8'(LOWP_ACQ_CYC);
        per_min = 8'(LOWP_PERIOD_CYC);
      end
      MODE_NORMAL: begin
        acq_min = 8'(NORMAL_ACQ_CYC);
        per_min = 8'(NORMAL_PERIOD_CYC);
      end
      default: begin
        acq_min = 8'(NORMAL_ACQ_CYC);
        per_min = 8'(NORMAL_PERIOD_CYC);
      end
    endcase
  end

  // Acquisition length counter
  always_ff @(posedge clk_i) begin
    if (rst_i || state_q != ST_ACQ) begin
      acq_cnt_q <= 8'h00;
    end else if (!acq_done) begin
      acq_cnt_q <= acq_cnt_q + 8'h01;
    end
  end

  assign acq_done = (acq_cnt_q >= acq_min - 8'h01);

  // Start needs a high level since the last start, except in low-power mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      armed_q <= 1'b1;
    end else if (trigger) begin
      armed_q <= 1'b0;
    end else if (conversion_start_n_i) begin
      armed_q <= 1'b1;
    end
  end

  assign trigger = (state_q == ST_ACQ) && acq_done && !conversion_start_n_i
                   && !power_down_input_i
                   && (armed_q || mode == MODE_LOWP);

  // ****************************************
  // Sequence state machine
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_ACQ;
    end else begin
      unique case (state_q)
        ST_ACQ: begin
          if (power_down_input_i) begin
            state_q <= ST_PD;
          end else if (trigger) begin
            state_q <= ST_OPEN;
          end
        end
        ST_OPEN: begin
          state_q <= ST_MOVE;
        end
        ST_MOVE: begin
          state_q <= ST_SEARCH;
        end
        ST_SEARCH: begin
          if (sar.done) begin
            state_q <= ST_LATCH;
          end
        end
        ST_LATCH: begin
          state_q <= power_down_input_i ? ST_PD : ST_ACQ;
        end
        ST_PD: begin
          if (!power_down_input_i) begin
            state_q <= ST_ACQ;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Result and flags
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_q <= 16'h0000;
      latch_q  <= 1'b0;
    end else begin
      latch_q <= (state_q == ST_SEARCH) && sar.done;
      if ((state_q == ST_SEARCH) && sar.done) begin
        result_q <= sar.code;
      end
    end
  end

  // New-result flag: set wins over the read clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      new_q <= 1'b0;
    end else if (latch_q) begin
      new_q <= 1'b1;
    end else if (wb_req && !wb_we_i && wb_adr_i == RESULT_OFS) begin
      new_q <= 1'b0;
    end
  end

  // Idle time since the last start, for the fast-mode stale flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idle_cnt_q <= 16'(STALE_LIMIT);
      stale_q    <= 1'b0;
    end else if (trigger) begin
      idle_cnt_q <= 16'h0000;
      stale_q    <= (mode == MODE_FAST) && (idle_cnt_q >= 16'(STALE_LIMIT));
    end else if (idle_cnt_q < 16'(STALE_LIMIT)) begin
      idle_cnt_q <= idle_cnt_q + 16'h0001;
    end
  end

  // ****************************************
  // Pin outputs
  // ****************************************
  assign busy_o                = (state_q inside {ST_OPEN, ST_MOVE, ST_SEARCH, ST_LATCH});
  assign array_ground_switch_o = (state_q == ST_ACQ) || (state_q == ST_PD);
  assign dummy_ground_switch_o = (state_q == ST_ACQ) || (state_q == ST_PD);
  assign inputs_connected_o    = (state_q inside {ST_ACQ, ST_PD, ST_OPEN});
  assign element_ref_o         = (state_q == ST_SEARCH) ? sar.code : 16'h0000;
  assign result_o              = result_q;
  assign result_latch_o        = latch_q;
  assign power_save_o          = (mode == MODE_LOWP) && (state_q == ST_ACQ) && acq_done;
  assign power_reduced_o       = (state_q == ST_PD);

  // ****************************************
  // Wishbone slave
  // ****************************************
  assign wb_req   = wb_cyc_i && wb_stb_i && !ack_q;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= wb_req;
      if (wb_req && !wb_we_i) begin
        unique case (wb_adr_i)
          CTRL_OFS:   dat_q <= {30'h0, ctrl_q};
          STATUS_OFS: dat_q <= {26'h0, mode, power_reduced_o, stale_q, new_q, busy_o};
          RESULT_OFS: dat_q <= {16'h0000, result_q};
          default:    dat_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RST;
    end else if (wb_req && wb_we_i && wb_adr_i == CTRL_OFS && wb_sel_i[0]) begin
      ctrl_q <= wb_dat_i[1:0];
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  logic [7:0] busy_len_q;
  logic [7:0] since_start_q;
  logic       started_q;

  always_ff @(posedge clk_i) begin
    if (rst_i || !busy_o) begin
      busy_len_q <= 8'h00;
    end else begin
      busy_len_q <= busy_len_q + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      since_start_q <= 8'h00;
      started_q     <= 1'b0;
    end else if (trigger) begin
      since_start_q <= 8'h00;
      started_q     <= 1'b1;
    end else if (since_start_q != 8'hFF) begin
      since_start_q <= since_start_q + 8'h01;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_start_busy: assert property (trigger |=> busy_o && !array_ground_switch_o)
    else $error("start did not begin a conversion");
  a_acq_switches: assert property (state_q == ST_ACQ |-> array_ground_switch_o && inputs_connected_o
                                   && element_ref_o == 16'h0000)
    else $error("acquisition switches wrong");
  a_open_first: assert property (trigger |=> !dummy_ground_switch_o && inputs_connected_o
                                 ##1 !inputs_connected_o && element_ref_o == 16'h0000)
    else $error("ground switches not opened before moving array");
  a_msb_first: assert property (state_q == ST_MOVE |=> element_ref_o == 16'h8000)
    else $error("first trial is not the top element");
  a_busy_drop: assert property (latch_q |-> busy_o ##1 !busy_o && result_o == $past(result_q))
    else $error("busy did not fall after result");
  a_no_latency: assert property (state_q == ST_SEARCH && sar.done |=> result_o == $past(sar.code))
    else $error("result not taken from this conversion");
  a_rate_limit: assert property (trigger && started_q |-> since_start_q >= per_min - 8'h01)
    else $error("conversion rate above mode limit");
  a_busy_length: assert property ($fell(busy_o) && !$past(rst_i) |-> busy_len_q == 8'(CONV_CYC))
    else $error("conversion length not fixed");
  a_reset_abort: assert property (@(posedge clk_i) disable iff (1'b0) rst_i |=> !busy_o && state_q == ST_ACQ)
    else $error("reset did not abort");
  a_lowp_immediate: assert property (state_q == ST_ACQ && acq_done && mode == MODE_LOWP
                                     && !conversion_start_n_i && !power_down_input_i |=> busy_o)
    else $error("low-power start not immediate");
  a_pd_block: assert property (power_down_input_i && !busy_o |=> !busy_o)
    else $error("conversion started in power-down");

  c_conversion: cover property ($fell(busy_o));
  c_pd_entry: cover property ($rose(power_reduced_o));
  c_lowp_held: cover property (trigger && mode == MODE_LOWP && !armed_q);
  c_stale: cover property (trigger && mode == MODE_FAST && idle_cnt_q >= 16'(STALE_LIMIT));

endmodule : sar_conversion_sequencer

/* rtl/sar_seq_pkg.sv */
/*
  Constants for the successive-approximation conversion sequencer:
  timing counts, register map and field positions, mode type.
  Assumes a 40 MHz system clock.
*/
package sar_seq_pkg;

  // ****************************************
  // Clock and resolution
  // ****************************************
  localparam int unsigned CLK_HZ   = 40_000_000;
  localparam int unsigned RES_BITS = 16;

  // ****************************************
  // Throughput per mode, samples per second
  // ****************************************
  localparam int unsigned FAST_SPS   = 570_000;
  localparam int unsigned NORMAL_SPS = 500_000;
  localparam int unsigned LOWP_SPS   = 444_000;

  // Least period, rounded up to whole cycles
  localparam int unsigned FAST_PERIOD_CYC   = (CLK_HZ + FAST_SPS - 1) / FAST_SPS;
  localparam int unsigned NORMAL_PERIOD_CYC = (CLK_HZ + NORMAL_SPS - 1) / NORMAL_SPS;
  localparam int unsigned LOWP_PERIOD_CYC   = (CLK_HZ + LOWP_SPS - 1) / LOWP_SPS;

  // ****************************************
  // Conversion phase lengths, cycles
  // ****************************************
  localparam int unsigned OPEN_CYC   = 1;
  localparam int unsigned MOVE_CYC   = 1;
  localparam int unsigned SEARCH_CYC = RES_BITS + 1;
  localparam int unsigned LATCH_CYC  = 1;
  localparam int unsigned CONV_CYC   = OPEN_CYC + MOVE_CYC + SEARCH_CYC + LATCH_CYC;

  localparam int unsigned FAST_ACQ_CYC   = FAST_PERIOD_CYC - CONV_CYC;
  localparam int unsigned NORMAL_ACQ_CYC = NORMAL_PERIOD_CYC - CONV_CYC;
  localparam int unsigned LOWP_ACQ_CYC   = LOWP_PERIOD_CYC - CONV_CYC;

  // Idle time after which a fast-mode result is stale
  localparam int unsigned STALE_TIME_US = 1000;
  localparam int unsigned STALE_CYC     = STALE_TIME_US * (CLK_HZ / 1_000_000);

  // ****************************************
  // Register map, byte addresses
  // ****************************************
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] RESULT_OFS = 8'h08;

  localparam int unsigned CTRL_FAST_BIT = 0;
  localparam int unsigned CTRL_LOWP_BIT = 1;
  localparam logic [1:0]  CTRL_RST      = 2'h0;

  localparam int unsigned ST_BUSY_BIT  = 0;
  localparam int unsigned ST_NEW_BIT   = 1;
  localparam int unsigned ST_STALE_BIT = 2;
  localparam int unsigned ST_PD_BIT    = 3;
  localparam int unsigned ST_MODE_LSB  = 4;

  typedef enum logic [1:0] {MODE_NORMAL, MODE_FAST, MODE_LOWP} mode_e;

endpackage : sar_seq_pkg

/* rtl/sar_if.sv */
/*
  Link between the sequencer and its search engine.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface sar_if;
  logic        start;
  logic        comp;
  logic [15:0] code;
  logic        done;

  modport engine (input start, input comp, output code, output done);
  modport ctrl   (output start, output comp, input code, input done);
endinterface : sar_if

/* rtl/sar_search.sv */
/*
  Binary search engine: one bit decision per clock, MSB first.
  Assumes comp high means the trial code does not exceed the sample.
*/
`timescale 1ns/1ps
module sar_search
  import sar_seq_pkg::*;
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Sequencer side
  sar_if.engine     bus
);

  logic [15:0] code_q;
  logic [3:0]  bit_q;
  logic        run_q;
  logic        done_q;

  assign bus.code = code_q;
  assign bus.done = done_q;

  // ****************************************
  // Trial and decide
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      code_q <= 16'h0000;
      bit_q  <= 4'h0;
      run_q  <= 1'b0;
    end else if (bus.start) begin
      code_q <= 16'h8000;
      bit_q  <= 4'hF;
      run_q  <= 1'b1;
    end else if (run_q) begin
      code_q[bit_q] <= bus.comp;
      if (bit_q != 4'h0) begin
        code_q[bit_q - 4'h1] <= 1'b1;
        bit_q                <= bit_q - 4'h1;
      end else begin
        run_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_q <= 1'b0;
    end else begin
      done_q <= run_q && (bit_q == 4'h0) && !bus.start;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_msb_trial: assert property (@(posedge clk_i) disable iff (rst_i) bus.start |=> code_q == 16'h8000)
    else $error("search does not begin at the top bit");
  a_one_step: assert property (@(posedge clk_i) disable iff (rst_i)
    run_q && !bus.start && bit_q != 4'h0 |=> run_q && bit_q == $past(bit_q) - 4'h1)
    else $error("search did not step one bit per cycle");

endmodule : sar_search

/* testbench/host_model.sv */
/*
  Host stand-in: drives conversion start and power-down, and answers
  the comparator from a sample held for the whole conversion.
  Assumes the trial code is shown on element_ref_i.
*/
`timescale 1ns/1ps
module host_model (
  // Clock
  input  wire logic        clk_i,
  // From the sequencer
  input  wire logic        busy_i,
  input  wire logic [15:0] element_ref_i,
  // To the sequencer
  output logic             conversion_start_n_o,
  output logic             power_down_o,
  output logic             comparator_o
);
  logic [15:0] sample_q;
  logic        timed_out;

  initial begin
    conversion_start_n_o = 1'b1;
    power_down_o         = 1'b0;
    sample_q             = 16'h0000;
    timed_out            = 1'b0;
  end

  // Keep the trial bit while the trial code is not above the sample
  assign comparator_o = (element_ref_i <= sample_q);

  // Wait for idle, hold a new sample, request; start may stay low
  task automatic convert(input logic [15:0] value, input bit keep_low);
    int t;
    t = 0;
    while (busy_i === 1'b1 && t < 300) begin
      @(posedge clk_i);
      t++;
    end
    sample_q             <= value;
    conversion_start_n_o <= 1'b0;
    do begin
      @(posedge clk_i);
      t++;
    end while (busy_i !== 1'b1 && t < 300);
    if (!keep_low) conversion_start_n_o <= 1'b1;
    if (t >= 300) timed_out = 1'b1;
  endtask : convert
endmodule : host_model

/* testbench/tb.sv */
/*
  Self-checking bench of the conversion sequencer: registers over
  Wishbone, conversions in all modes, power-down, reset abort.
  Assumes host_model as host and comparator.
*/
`timescale 1ns/1ps
module tb;
  import sar_seq_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rdat;
  logic        conversion_start_n_i, power_down_input_i, comparator_i;
  logic        busy_o, array_ground_switch_o, dummy_ground_switch_o;
  logic        inputs_connected_o, result_latch_o, power_save_o;
  logic        power_reduced_o, busy_d;
  logic [15:0] element_ref_o, result_o, v;
  int          mismatches, num_checks, tick, rise_at, cnt, n;
  int          exp_q[$];
  int          gaps[$];
  logic [15:0] corner[4]    = '{16'h0000, 16'hFFFF, 16'h8000, 16'h7FFF};
  logic [31:0] ctrl_v[3]    = '{32'h0, 32'h1, 32'h2};
  mode_e       mode_v[3]    = '{MODE_NORMAL, MODE_FAST, MODE_LOWP};
  int          period_v[3]  = '{NORMAL_PERIOD_CYC, FAST_PERIOD_CYC, LOWP_PERIOD_CYC};

  sar_conversion_sequencer #(.STALE_LIMIT(200)) dut_u (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .conversion_start_n_i, .power_down_input_i,
    .comparator_i, .busy_o, .array_ground_switch_o, .dummy_ground_switch_o,
    .inputs_connected_o, .element_ref_o, .result_o, .result_latch_o,
    .power_save_o, .power_reduced_o
  );

  host_model host_u (
    .clk_i, .busy_i(busy_o), .element_ref_i(element_ref_o),
    .conversion_start_n_o(conversion_start_n_i),
    .power_down_o(power_down_input_i), .comparator_o(comparator_i)
  );

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("Checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results

  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d, output logic [31:0] q);
    int t;
    t = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    check(t < 20, 1'b1);
    @(posedge clk_i);
  endtask : wb

  // ****************************************
  // Per-cycle conversion model
  // ****************************************
  always @(posedge clk_i) begin
    tick++;
    if (rst_i) begin
      cnt = -1;
      exp_q.delete();
    end else begin
      if (busy_o === 1'b1 && busy_d !== 1'b1) begin
        cnt = 0;
        gaps.push_back(tick - rise_at);
        rise_at = tick;
        check({array_ground_switch_o, dummy_ground_switch_o, inputs_connected_o}, 3'b001);
      end else if (cnt >= 0) cnt++;
      if (cnt == 1) check({inputs_connected_o, element_ref_o}, 17'h0);
      if (cnt == 2) check(element_ref_o, 16'h8000);
      if (result_latch_o === 1'b1) begin
        check(cnt, 19);
        check(busy_o, 1'b1);
        check(result_o, exp_q.pop_front());
      end
      if (busy_o !== 1'b1) begin
        if (cnt >= 0) check(cnt, 20);
        cnt = -1;
        if (power_reduced_o !== 1'b1)
          check({array_ground_switch_o, dummy_ground_switch_o, inputs_connected_o, element_ref_o}, 19'h70000);
      end
    end
    busy_d = busy_o;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    results();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {mismatches, num_checks, tick, rise_at, busy_d, cnt} = '0;
    void'($urandom(32'h4CFA));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check({busy_o, array_ground_switch_o, dummy_ground_switch_o, inputs_connected_o,
           power_reduced_o}, 5'b01110);
    check({element_ref_o, result_o}, 32'h0);
    wb(1'b1, CTRL_OFS, 4'h0, 32'h1, rdat);
    wb(1'b0, CTRL_OFS, 4'hF, 32'h0, rdat);
    check(rdat, 32'h0);
    wb(1'b1, 8'h0C, 4'hF, 32'hFFFF_FFFF, rdat);
    wb(1'b0, 8'h0C, 4'hF, 32'h0, rdat);
    check(rdat, 32'h0);
    wb(1'b1, CTRL_OFS, 4'h1, 32'h3, rdat);
    wb(1'b0, STATUS_OFS, 4'hF, 32'h0, rdat);
    check(rdat[ST_MODE_LSB +: 2], MODE_FAST);
    $display("Test registers done");
    for (int m = 0; m < 3; m++) begin
      wb(1'b1, CTRL_OFS, 4'h1, ctrl_v[m], rdat);
      wb(1'b0, STATUS_OFS, 4'hF, 32'h0, rdat);
      check(rdat[ST_MODE_LSB +: 2], mode_v[m]);
      gaps.delete();
      for (int k = 0; k < 6; k++) begin
        v = (k < 4) ? corner[k] : 16'($urandom);
        exp_q.push_back(v);
        host_u.convert(v, m == 2);
      end
      if (m == 2) host_u.conversion_start_n_o <= 1'b1;
      repeat ((m == 2) ? 95 : 25) @(posedge clk_i);
      check(power_save_o, m == 2);
      // First gap follows register traffic, so only prompt ones count
      for (int k = 1; k < gaps.size(); k++) check(gaps[k], period_v[m]);
      $display("Test mode %0d done", m);
    end
    wb(1'b0, STATUS_OFS, 4'hF, 32'h0, rdat);
    check(rdat[ST_NEW_BIT], 1'b1);
    wb(1'b0, RESULT_OFS, 4'hF, 32'h0, rdat);
    check(rdat, {16'h0, v});
    wb(1'b0, STATUS_OFS, 4'hF, 32'h0, rdat);
    check(rdat[ST_NEW_BIT], 1'b0);
    wb(1'b1, CTRL_OFS, 4'h1, 32'h0, rdat);
    v = 16'($urandom);
    exp_q.push_back(v);
    host_u.convert(v, 1'b0);
    host_u.power_down_o <= 1'b1;
    repeat (25) @(posedge clk_i);
    check(exp_q.size(), 0);
    check(power_reduced_o, 1'b1);
    host_u.conversion_start_n_o <= 1'b0;
    n = gaps.size();
    repeat (150) @(posedge clk_i);
    check(gaps.size(), n);
    host_u.power_down_o <= 1'b0;
    host_u.conversion_start_n_o <= 1'b1;
    @(posedge clk_i);
    v = 16'($urandom);
    exp_q.push_back(v);
    host_u.convert(v, 1'b0);
    repeat (25) @(posedge clk_i);
    check(exp_q.size(), 0);
    $display("Test power-down done");
    wb(1'b1, CTRL_OFS, 4'h1, 32'h1, rdat);
    exp_q.push_back(16'h5A5A);
    host_u.convert(16'h5A5A, 1'b0);
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check({busy_o, result_o}, 17'h0);
    wb(1'b0, CTRL_OFS, 4'hF, 32'h0, rdat);
    check(rdat, 32'h0);
    $display("Test reset abort done");
    wb(1'b1, CTRL_OFS, 4'h1, 32'h1, rdat);
    for (int k = 0; k < 2; k++) begin
      v = 16'($urandom);
      exp_q.push_back(v);
      host_u.convert(v, 1'b0);
      wb(1'b0, STATUS_OFS, 4'hF, 32'h0, rdat);
      check(rdat[ST_STALE_BIT], k == 0);
    end
    repeat (25) @(posedge clk_i);
    check(exp_q.size(), 0);
    check(host_u.timed_out, 1'b0);
    $display("Test stale result done");
    results();
  end
endmodule : tb
